// File: rtl/bus_ctrl_pkg.sv
// Constants and types shared by the bus control unit core.
// Assumes a 25 MHz system clock; the modem bit clock is divided from it.
package bus_ctrl_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int          CLK_MHZ          = 25;
	localparam int          TX_BIT_NS        = 320;
	localparam logic [3:0]  TX_DIV_CYC       = 4'(TX_BIT_NS * CLK_MHZ / 1000);
	localparam logic [3:0]  TX_HALF_CYC      = 4'(TX_BIT_NS * CLK_MHZ / 2000);
	localparam int          RESP_TIMEOUT_US  = 100;
	localparam logic [11:0] RESP_TIMEOUT_CYC = 12'(RESP_TIMEOUT_US * CLK_MHZ);
	// ----------------------------------------
	// Stepping and framing
	// ----------------------------------------
	localparam logic [3:0]  BURST_PULSES = 4'h8;
	localparam logic [3:0]  SINGLE_PULSE = 4'h1;
	localparam logic [3:0]  BLOCK_BYTES  = 4'he;
	localparam logic [3:0]  CODE_BITS    = 4'hf;
	localparam logic [6:0]  RX_DATA_BITS = 7'h70;
	localparam logic [6:0]  RX_CODE_END  = 7'h7e;
	localparam logic [6:0]  RX_ZERO_POS  = 7'h7f;
	// Generator taps below x^15; plain default, replace with the real polynomial
	localparam logic [14:0] BCH_POLY     = 15'h0b2d;
	localparam int          TXF_WIDTH    = 9;
	localparam int          TXF_DEPTH    = 16;
	// ----------------------------------------
	// Opcodes, mode word, pulses, status, pins
	// ----------------------------------------
	localparam logic [2:0] OP_COMPARE     = 3'h1;
	localparam logic [2:0] OP_SET_MODE    = 3'h3;
	localparam logic [2:0] OP_MEM_REMOTE  = 3'h2;
	localparam logic [2:0] OP_HOST_REMOTE = 3'h7;
	localparam logic [2:0] OP_HOST_CTRL   = 3'h5;
	localparam int MB_ERR_GEN = 0, MB_BIT_STEP = 1, MB_BYTE_STEP = 2, MB_INST_STEP = 3;
	localparam int MB_TX_B = 4, MB_RX_B = 5, MB_CLEAR = 6, MODE_W = 7;
	localparam int OPP_COMPARE = 0, OPP_SET_MODE = 1, OPP_MEM_REMOTE = 2;
	localparam int OPP_HOST_REMOTE = 3, OPP_HOST_CTRL = 4, OPP_W = 5;
	localparam int ST_BCH = 0, ST_NO_RESP = 1, ST_ADDR = 2, ST_BUSY = 3, ST_HOST_WR = 4;
	localparam int ST_INST = 5, ST_CMP = 6, ST_HOST_PAR = 7, ST_TAPE = 8, ST_W = 9;
	localparam int RXP_DATA = 0, RXP_CLK = 1, RXP_SOM = 2, RXP_MOD = 3;
	localparam int TXP_DATA = 0, TXP_SOM = 1, TXP_EN = 2;
	typedef enum logic [1:0] {SW_CENTRE, SW_OFF, SW_ON} swpos_t;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CODE, TX_ZERO} tx_state_t;
endpackage

// File: rtl/bus_control_unit.sv
// Control core of the bus control unit: stepping, BCH framing, modem
// channel routing, error stop and opcode decode, plus its transmit FIFO.
// Assumes host-side strobes are on mclk; panel and modem pins are async.
//
// Function
// - Byte step: each advance releases exactly eight timing pulses, then holds.
// - Byte-step switch off disables it; centre lets the software bit decide.
// - Instruction step: one whole instruction runs per advance; off/centre as above.
// - With coding on, 15-bit check code plus a zero bit follows every 14 bytes.
// - With coding on, received messages are checked and mismatches flagged.
// - With coding off, no code is inserted or checked; txCrc still accumulates over data bits.
// - Error injection flips one bit of the final check code, only with coding on.
// - Error stop halts and reports status to host; otherwise only host parity and tape parity errors halt.
// - Error stop covers coding, no reply, address, busy, host write, opcode, compare.
// - Host data parity error always halts.
// - Transmit select routes data, start pulse and enable to modem A or B only.
// - Receive select gates data, clock, start pulse and carrier from A or B.
// - One continuous transmit clock drives both modems regardless of selection.
// - Comparator output is high exactly one bit time per byte mismatch.
// - Compare mode compares transmitted and received memory bytes one at a time.
// - Tape parity error sets the tape flag and forces error stop.
// - No reply within the timeout sets the no-reply flag and error stop.
// - Invalid address mode in a reply sets the wrong-reply flag and error stop.
// - Undefined opcode sets the invalid-instruction flag and error stop.
// - Basic mode selects instruction source: internal memory or host unit.
// - Memory-mode opcodes: 001 compare, 011 set mode, 010 remote transfer.
// - Clock step releases one pulse per advance and overrides software.
// - Host-mode opcodes: 111 host-remote, 101 host-controller, 011 set mode.
`timescale 1ns/1ps

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wrPtr;
		logic [AW:0]                 rdPtr;
		logic                        ready;
	} fifo_state_t;
	fifo_state_t q;
	fifo_state_t d;

	// Ready is registered so the host sees a flop, not pointer logic
	always_comb begin
		d = q;
		if (inValid && q.ready) begin
			d.mem[q.wrPtr[AW-1:0]] = inData;
			d.wrPtr = q.wrPtr + 1'b1;
		end
		if (outReady && outValid) begin
			d.rdPtr = q.rdPtr + 1'b1;
		end
		d.ready = (d.wrPtr[AW-1:0] != d.rdPtr[AW-1:0]) || (d.wrPtr[AW] == d.rdPtr[AW]);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign inReady  = q.ready;
	assign outValid = q.wrPtr != q.rdPtr;
	assign outData  = q.mem[q.rdPtr[AW-1:0]];
endmodule

// ----------------------------------------
// Control core
// ----------------------------------------
module bus_control_unit
	import bus_ctrl_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              advanceIn,
	input  wire swpos_t            clockStepSw,
	input  wire swpos_t            byteStepSw,
	input  wire swpos_t            instStepSw,
	input  wire swpos_t            errGenSw,
	input  wire swpos_t            txSelSw,
	input  wire swpos_t            rxSelSw,
	input  wire logic              bchEnable,
	input  wire logic              errStopEnable,
	input  wire logic              runReq,
	input  wire logic              haltReq,
	input  wire logic              hostMode,
	input  wire logic              instValid,
	input  wire logic [2:0]        opcode,
	input  wire logic [MODE_W-1:0] modeBits,
	input  wire logic              instDone,
	input  wire logic [7:0]        hostByte,
	input  wire logic              hostByteLast,
	input  wire logic              hostByteValid,
	output logic                   hostByteReady,
	input  wire logic              cmpValid,
	input  wire logic [7:0]        cmpByteTx,
	input  wire logic [7:0]        cmpByteRx,
	input  wire logic              cmpOverride,
	input  wire logic              expectReply,
	input  wire logic              rxAddrModeErr,
	input  wire logic              lineBusyErr,
	input  wire logic              hostWriteNoResp,
	input  wire logic              hostParityErr,
	input  wire logic              tapeParityErr,
	input  wire logic              clearStatus,
	output logic                   serialTxDataA,
	output logic                   serialTxDataB,
	output logic                   txMessageStartPulseA,
	output logic                   txMessageStartPulseB,
	output logic                   txEnableA,
	output logic                   txEnableB,
	output logic                   txSharedClock,
	input  wire logic              serialRxDataA,
	input  wire logic              serialRxDataB,
	input  wire logic              rxRecoveredClockA,
	input  wire logic              rxRecoveredClockB,
	input  wire logic              rxMessageStartPulseA,
	input  wire logic              rxMessageStartPulseB,
	input  wire logic              modPresentA,
	input  wire logic              modPresentB,
	output logic                   timingEn,
	output logic                   timingPulse,
	output logic                   running,
	output logic                   instSrcHost,
	output logic [7:0]             rxByte,
	output logic                   rxByteValid,
	output logic                   comparatorOut,
	output logic [ST_W-1:0]        statusWord,
	output logic                   statusValid,
	output logic                   opCompare,
	output logic                   opSetMode,
	output logic                   opMemRemote,
	output logic                   opHostRemote,
	output logic                   opHostCtrl,
	output logic                   clockStepMode,
	output logic                   byteStepMode,
	output logic                   instructionStepMode,
	output logic                   errGenActive,
	output logic                   txOnB,
	output logic                   rxOnB
);
	typedef struct packed {
		swpos_t clk;
		swpos_t byteStep;
		swpos_t instStep;
		swpos_t errGen;
		swpos_t txSel;
		swpos_t rxSel;
		logic   bchEn;
		logic   errStopEn;
	} panel_t;

	typedef struct packed {
		panel_t            panelMeta;
		panel_t            panelSync;
		logic              advMeta;
		logic              advSync;
		logic              advPrev;
		logic [3:0]        rxAMeta;
		logic [3:0]        rxASync;
		logic [3:0]        rxBMeta;
		logic [3:0]        rxBSync;
		logic              rxClkPrev;
		logic              rxSomPrev;
		logic              running;
		logic              instSrcHost;
		logic              timingEn;
		logic              timingPulse;
		logic [3:0]        burst;
		logic              instGo;
		logic [MODE_W-1:0] swMode;
		logic [3:0]        divCnt;
		logic              txClk;
		tx_state_t         txState;
		logic [7:0]        txShift;
		logic [2:0]        txBit;
		logic [3:0]        txByteCnt;
		logic              txLastSeen;
		logic [14:0]       txCrc;
		logic [3:0]        codeCnt;
		logic              txOut;
		logic              txSom;
		logic              txEn;
		logic [2:0]        txPinsA;
		logic [2:0]        txPinsB;
		logic              rxActive;
		logic [6:0]        rxPos;
		logic [7:0]        rxShift;
		logic [14:0]       rxCrc;
		logic [7:0]        rxByte;
		logic              rxByteValid;
		logic              cmpActive;
		logic [3:0]        cmpCnt;
		logic              cmpOut;
		logic [11:0]       toCnt;
		logic [ST_W-1:0]   status;
		logic              statusValid;
		logic [OPP_W-1:0]  opPulse;
		logic [5:0]        lamps;
	} state_t;

	state_t            q;
	state_t            d;
	panel_t            panelRaw;
	logic              fifoValid;
	logic [8:0]        fifoData;
	logic              pop;
	logic              loadNext;
	logic              msgEnd;
	logic              setMode;
	logic              clkSel;
	logic              byteSel;
	logic              instSel;
	logic              bchOn;
	logic              inject;
	logic              txB;
	logic              rxB;
	logic              advRise;
	logic              bitTick;
	logic              allow;
	logic              stp;
	logic [3:0]        rxSel;
	logic              rxEdge;
	logic              somRise;
	logic              clrStat;
	logic              haltNow;
	logic [ST_W-1:0]   err;

	// Panel position wins when not centred
	function automatic logic pick(input swpos_t pos, input logic softBit);
		case (pos)
			SW_ON: pick = 1'b1;
			SW_OFF: pick = 1'b0;
			default: pick = softBit;
		endcase
	endfunction

	// One serial step of the check-code divider
	function automatic logic [14:0] bchStep(input logic [14:0] rem, input logic bitIn);
		logic fb;
		fb = rem[14] ^ bitIn;
		bchStep = {rem[13:0], 1'b0} ^ (fb ? BCH_POLY : 15'h0000);
	endfunction

	assign panelRaw = panel_t'({clockStepSw, byteStepSw, instStepSw, errGenSw,
		txSelSw, rxSelSw, bchEnable, errStopEnable});

	// FIFO back-pressure reaches the host through hostByteReady
	tx_fifo #(
		.WIDTH (TXF_WIDTH),
		.DEPTH (TXF_DEPTH)
	) u_tx_fifo (
		.clk      (mclk),
		.rst      (sys_rst),
		.inValid  (hostByteValid),
		.inData   ({hostByteLast, hostByte}),
		.inReady  (hostByteReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (pop)
	);

	always_comb begin
		d = q;
		pop = 1'b0;
		loadNext = 1'b0;
		msgEnd = 1'b0;
		setMode = 1'b0;
		err = '0;
		// Async pins: second flop is the only reader of the first
		d.panelMeta = panelRaw;
		d.panelSync = q.panelMeta;
		d.advMeta = advanceIn;
		d.advSync = q.advMeta;
		d.advPrev = q.advSync;
		d.rxAMeta = {modPresentA, rxMessageStartPulseA, rxRecoveredClockA, serialRxDataA};
		d.rxASync = q.rxAMeta;
		d.rxBMeta = {modPresentB, rxMessageStartPulseB, rxRecoveredClockB, serialRxDataB};
		d.rxBSync = q.rxBMeta;

		clkSel = pick(q.panelSync.clk, q.swMode[MB_BIT_STEP]);
		byteSel = pick(q.panelSync.byteStep, q.swMode[MB_BYTE_STEP]) & ~clkSel;
		instSel = pick(q.panelSync.instStep, q.swMode[MB_INST_STEP]) & ~clkSel & ~byteSel;
		bchOn = q.panelSync.bchEn;
		inject = pick(q.panelSync.errGen, q.swMode[MB_ERR_GEN]) & bchOn;
		txB = pick(q.panelSync.txSel, q.swMode[MB_TX_B]);
		rxB = pick(q.panelSync.rxSel, q.swMode[MB_RX_B]);
		advRise = q.advSync & ~q.advPrev;

		// Free-running bit clock for both modems
		bitTick = q.divCnt == TX_DIV_CYC - 4'h1;
		d.divCnt = bitTick ? 4'h0 : q.divCnt + 4'h1;
		d.txClk = (d.divCnt != 4'h0) && (d.divCnt <= TX_HALF_CYC); // High for four cycles, starting one cycle after divCnt wraps to zero

		// Timing gate; one internal pulse is one bit tick
		allow = q.running & ((clkSel | byteSel) ? (q.burst != 4'h0) : (instSel ? q.instGo : 1'b1));
		stp = bitTick & allow;
		if (stp && q.burst != 4'h0) begin
			d.burst = q.burst - 4'h1;
		end
		if (!(clkSel | byteSel)) begin
			d.burst = 4'h0;
		end
		if (instDone || !instSel) begin
			d.instGo = 1'b0;
		end
		// Advance during a running burst is ignored, not stacked
		if (advRise && q.running) begin
			if (clkSel && q.burst == 4'h0) begin
				d.burst = SINGLE_PULSE;
			end else if (byteSel && q.burst == 4'h0) begin
				d.burst = BURST_PULSES;
			end else if (instSel) begin
				d.instGo = 1'b1;
			end
		end
		d.timingEn = allow;
		d.timingPulse = stp;

		// Transmit framer, advanced only by released pulses
		case (q.txState)
			TX_IDLE: begin
				if (stp) begin
					d.txEn = 1'b0;
					d.txSom = 1'b0;
					d.txOut = 1'b0;
					if (fifoValid) begin
						d.txEn = 1'b1;
						d.txSom = 1'b1;
						d.txByteCnt = 4'h0;
						d.txCrc = '0;
						d.txBit = 3'h0;
						d.txLastSeen = 1'b0;
						loadNext = 1'b1;
						d.txState = TX_DATA;
					end
				end
			end
			TX_DATA: begin
				if (stp) begin
					d.txSom = 1'b0;
					d.txOut = q.txShift[7];
					d.txCrc = bchStep(q.txCrc, q.txShift[7]);
					d.txShift = {q.txShift[6:0], 1'b0};
					d.txBit = q.txBit + 3'h1;
					if (q.txBit == 3'h7) begin
						d.txByteCnt = q.txByteCnt + 4'h1;
						if (bchOn && q.txByteCnt == BLOCK_BYTES - 4'h1) begin
							d.codeCnt = 4'h0;
							d.txState = TX_CODE;
						end else if (!bchOn && q.txLastSeen) begin
							msgEnd = 1'b1;
							d.txState = TX_IDLE;
						end else begin
							loadNext = 1'b1;
						end
					end
				end
			end
			TX_CODE: begin
				if (stp) begin
					// Flip first bit of final code
					d.txOut = q.txCrc[14] ^ (inject && q.txLastSeen && q.codeCnt == 4'h0);
					d.txCrc = {q.txCrc[13:0], 1'b0};
					d.codeCnt = q.codeCnt + 4'h1;
					if (q.codeCnt == CODE_BITS - 4'h1) begin
						d.txState = TX_ZERO;
					end
				end
			end
			TX_ZERO: begin
				if (stp) begin
					d.txOut = 1'b0;
					if (q.txLastSeen) begin
						msgEnd = 1'b1;
						d.txState = TX_IDLE;
					end else begin
						d.txByteCnt = 4'h0;
						d.txCrc = '0;
						d.txBit = 3'h0;
						loadNext = 1'b1;
						d.txState = TX_DATA;
					end
				end
			end
			default: begin
				d.txState = TX_IDLE;
			end
		endcase
		// Pad with zero bytes after the last one, and on underrun
		if (loadNext) begin
			if (!d.txLastSeen && fifoValid) begin
				d.txShift = fifoData[7:0];
				d.txLastSeen = fifoData[8];
				pop = 1'b1;
			end else begin
				d.txShift = 8'h00;
			end
		end
		// Only the chosen modem sees traffic
		d.txPinsA = txB ? 3'h0 : {d.txEn, d.txSom, d.txOut};
		d.txPinsB = txB ? {d.txEn, d.txSom, d.txOut} : 3'h0;

		// Receive group from the chosen modem
		rxSel = rxB ? q.rxBSync : q.rxASync;
		d.rxClkPrev = rxSel[RXP_CLK];
		d.rxSomPrev = rxSel[RXP_SOM];
		rxEdge = rxSel[RXP_CLK] & ~q.rxClkPrev;
		somRise = rxSel[RXP_SOM] & ~q.rxSomPrev;
		d.rxByteValid = 1'b0;
		if (!rxSel[RXP_MOD]) begin
			d.rxActive = 1'b0;
		end else if (rxSel[RXP_SOM]) begin
			d.rxActive = 1'b1;
			d.rxPos = 7'h00;
			d.rxCrc = '0;
		end else if (rxEdge && q.rxActive) begin
			if (!bchOn || q.rxPos < RX_DATA_BITS) begin
				d.rxShift = {q.rxShift[6:0], rxSel[RXP_DATA]};
				if (q.rxPos[2:0] == 3'h7) begin
					d.rxByte = d.rxShift;
					d.rxByteValid = 1'b1;
				end
			end
			// Divide data and code; remainder must be zero
			if (bchOn && q.rxPos != RX_ZERO_POS) begin
				d.rxCrc = bchStep(q.rxCrc, rxSel[RXP_DATA]);
			end
			if (bchOn && q.rxPos == RX_CODE_END && d.rxCrc != 15'h0000) begin
				err[ST_BCH] = 1'b1;
			end
			if (bchOn && q.rxPos == RX_ZERO_POS) begin
				d.rxCrc = '0;
			end
			d.rxPos = q.rxPos + 7'h01;
		end

		// Reply timer after a message that expects one
		if (q.toCnt != 12'h000) begin
			d.toCnt = q.toCnt - 12'h001;
			if (q.toCnt == 12'h001) begin
				err[ST_NO_RESP] = 1'b1;
			end
		end
		if (somRise) begin
			d.toCnt = 12'h000;
		end
		if (msgEnd && expectReply) begin
			d.toCnt = RESP_TIMEOUT_CYC;
		end

		// Instruction source follows the basic mode
		d.instSrcHost = hostMode;
		d.opPulse = '0;
		if (instDone) begin
			d.cmpActive = 1'b0;
		end
		if (instValid) begin
			if (hostMode) begin
				case (opcode)
					OP_HOST_REMOTE: d.opPulse[OPP_HOST_REMOTE] = 1'b1;
					OP_HOST_CTRL: d.opPulse[OPP_HOST_CTRL] = 1'b1;
					OP_SET_MODE: setMode = 1'b1;
					default: err[ST_INST] = 1'b1;
				endcase
			end else begin
				case (opcode)
					OP_COMPARE: begin
						d.opPulse[OPP_COMPARE] = 1'b1;
						d.cmpActive = 1'b1;
					end
					OP_MEM_REMOTE: d.opPulse[OPP_MEM_REMOTE] = 1'b1;
					OP_SET_MODE: setMode = 1'b1;
					default: err[ST_INST] = 1'b1;
				endcase
			end
		end
		if (setMode) begin
			d.opPulse[OPP_SET_MODE] = 1'b1;
			d.swMode = modeBits;
		end

		// One bit time high per mismatch
		if (q.cmpCnt != 4'h0) begin
			d.cmpCnt = q.cmpCnt - 4'h1;
		end
		if (cmpValid && q.cmpActive && cmpByteTx != cmpByteRx) begin
			d.cmpCnt = TX_DIV_CYC;
			err[ST_CMP] = 1'b1;
		end
		d.cmpOut = d.cmpCnt != 4'h0;

		err[ST_ADDR] = rxAddrModeErr;
		err[ST_BUSY] = lineBusyErr;
		err[ST_HOST_WR] = hostWriteNoResp;
		err[ST_HOST_PAR] = hostParityErr;
		err[ST_TAPE] = tapeParityErr;
		// New errors win over a clear in the same cycle
		clrStat = clearStatus | (setMode & modeBits[MB_CLEAR]);
		d.status = (clrStat ? '0 : q.status) | err;
		haltNow = q.panelSync.errStopEn & ((|err[ST_INST:ST_BCH]) | (err[ST_CMP] & ~cmpOverride));
		haltNow = haltNow | err[ST_HOST_PAR] | err[ST_TAPE];
		d.statusValid = haltNow;
		if (runReq) begin
			d.running = 1'b1;
		end
		if (haltReq || haltNow) begin
			d.running = 1'b0;
		end
		d.lamps = {rxB, txB, inject, instSel, byteSel, clkSel};
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Every output is a state flop
	assign serialTxDataA        = q.txPinsA[TXP_DATA];
	assign serialTxDataB        = q.txPinsB[TXP_DATA];
	assign txMessageStartPulseA = q.txPinsA[TXP_SOM];
	assign txMessageStartPulseB = q.txPinsB[TXP_SOM];
	assign txEnableA            = q.txPinsA[TXP_EN];
	assign txEnableB            = q.txPinsB[TXP_EN];
	assign txSharedClock        = q.txClk;
	assign timingEn             = q.timingEn;
	assign timingPulse          = q.timingPulse;
	assign running              = q.running;
	assign instSrcHost          = q.instSrcHost;
	assign rxByte               = q.rxByte;
	assign rxByteValid          = q.rxByteValid;
	assign comparatorOut        = q.cmpOut;
	assign statusWord           = q.status;
	assign statusValid          = q.statusValid;
	assign opCompare            = q.opPulse[OPP_COMPARE];
	assign opSetMode            = q.opPulse[OPP_SET_MODE];
	assign opMemRemote          = q.opPulse[OPP_MEM_REMOTE];
	assign opHostRemote         = q.opPulse[OPP_HOST_REMOTE];
	assign opHostCtrl           = q.opPulse[OPP_HOST_CTRL];
	assign clockStepMode        = q.lamps[0];
	assign byteStepMode         = q.lamps[1];
	assign instructionStepMode  = q.lamps[2];
	assign errGenActive         = q.lamps[3];
	assign txOnB                = q.lamps[4];
	assign rxOnB                = q.lamps[5];
endmodule

// File: test/bus_control_unit_props.sv
// Port checks for the bus control core.
// Assumes a bind into bus_control_unit; everything is in the mclk domain.
`timescale 1ns/1ps
module bus_control_unit_props
	import bus_ctrl_pkg::*;
(
	input wire logic            mclk,
	input wire logic            sys_rst,
	input wire logic            hostMode,
	input wire logic            instSrcHost,
	input wire logic            instValid,
	input wire logic [2:0]      opcode,
	input wire logic            hostParityErr,
	input wire logic            tapeParityErr,
	input wire logic            comparatorOut,
	input wire logic            txSharedClock,
	input wire logic            txOnB,
	input wire logic            txEnableA,
	input wire logic            txEnableB,
	input wire logic            serialTxDataB,
	input wire logic            running,
	input wire logic [ST_W-1:0] statusWord,
	input wire logic            opCompare,
	input wire logic            opHostRemote
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_hi; txSharedClock [*4]; endsequence
	sequence s_lo; !txSharedClock [*4]; endsequence
	property p_clk; $rose(txSharedClock) |-> s_hi ##1 s_lo ##1 txSharedClock; endproperty
	a_clk: assert property (p_clk) else $error("tx clock period wrong");
	property p_cmp; $rose(comparatorOut) |-> comparatorOut [*8] ##1 !comparatorOut; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator pulse width");
	property p_selA; !txOnB && !$past(txOnB) |-> !txEnableB && !serialTxDataB; endproperty
	a_selA: assert property (p_selA) else $error("channel B driven");
	property p_selB; txOnB && $past(txOnB) |-> !txEnableA; endproperty
	a_selB: assert property (p_selB) else $error("channel A driven");
	property p_par; hostParityErr |-> ##[1:3] !running; endproperty
	a_par: assert property (p_par) else $error("no halt on host parity");
	property p_tape; tapeParityErr |-> ##[1:3] statusWord[ST_TAPE]; endproperty
	a_tape: assert property (p_tape) else $error("tape flag missing");
	property p_mem; instValid && !hostMode && !instSrcHost && opcode == OP_COMPARE |=> opCompare;
	endproperty
	a_mem: assert property (p_mem) else $error("compare op not decoded");
	property p_host;
		instValid && hostMode && instSrcHost && opcode == OP_HOST_REMOTE |=> opHostRemote;
	endproperty
	a_host: assert property (p_host) else $error("host op not decoded");
	property p_bad; instValid && !hostMode && !instSrcHost && opcode == 3'h7
		|-> ##[1:3] statusWord[ST_INST]; endproperty
	a_bad: assert property (p_bad) else $error("bad opcode not flagged");
endmodule

// File: test/modem_model.sv
// Far-end modem on channel A: frames bytes MSB first on a 320 ns clock.
// Clock stands still outside frames; the data line then shows the inverse.
`timescale 1ns/1ps
module modem_model (
	output logic rxData,
	output logic rxClk,
	output logic rxSom,
	output logic carrier
);
	initial begin
		{rxData, rxClk, rxSom, carrier} = 4'h0;
	end
	// Bits change on the falling clock so the rising edge sees them settled
	task automatic send(input logic [7:0] b);
		carrier = 1'b1; rxSom = 1'b1; #320 rxSom = 1'b0; #320;
		for (int i = 7; i >= 0; i--) begin
			rxData = b[i]; #160 rxClk = 1'b1; #160 rxClk = 1'b0;
		end
		rxData = ~b[0]; carrier = 1'b0;
	endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for bus_control_unit with a modem on channel A.
// Assumes the package constants; unused host and error inputs stay low.
`timescale 1ns/1ps
module testbench;
	import bus_ctrl_pkg::*;
	logic mclk = 0, sys_rst = 1, advanceIn = 0, bchEnable = 0, errStopEnable = 0;
	logic runReq = 0, haltReq = 0, hostMode = 0, instValid = 0, instDone = 0, hostByteLast = 0;
	logic hostByteValid = 0, cmpValid = 0, cmpOverride = 0, expectReply = 0, rxAddrModeErr = 0;
	logic lineBusyErr = 0, hostWriteNoResp = 0, hostParityErr = 0, tapeParityErr = 0;
	logic clearStatus = 0, serialRxDataB = 0, rxRecoveredClockB = 0, rxMessageStartPulseB = 0;
	logic modPresentB = 0, serialRxDataA, rxRecoveredClockA, rxMessageStartPulseA, modPresentA;
	logic [2:0] opcode = 3'h0;
	logic [MODE_W-1:0] modeBits = '0;
	logic [7:0] hostByte = 8'h00, cmpByteTx = 8'h5a, cmpByteRx = 8'h5b, rxByte;
	swpos_t clockStepSw = SW_OFF, byteStepSw = SW_OFF, instStepSw = SW_OFF;
	swpos_t errGenSw = SW_OFF, txSelSw = SW_OFF, rxSelSw = SW_OFF;
	logic hostByteReady, serialTxDataA, serialTxDataB, txMessageStartPulseA;
	logic txMessageStartPulseB, txEnableA, txEnableB, txSharedClock, timingEn, timingPulse;
	logic running, instSrcHost, rxByteValid, comparatorOut, statusValid, opCompare, opSetMode;
	logic opMemRemote, opHostRemote, opHostCtrl, clockStepMode, byteStepMode;
	logic instructionStepMode, errGenActive, txOnB, rxOnB;
	logic [ST_W-1:0] statusWord;
	int errCount = 0, nCompared = 0;
	bus_control_unit dut (.*);
	modem_model modem (.rxData(serialRxDataA), .rxClk(rxRecoveredClockA),
		.rxSom(rxMessageStartPulseA), .carrier(modPresentA));
	always #20 mclk = ~mclk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic cyc(input int n); repeat (n) @(posedge mclk); endtask
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One advance press, then count released pulses over the settle span
	task automatic step(input string what, input int exp);
		int k;
		k = 0;
		advanceIn <= 1'b1; cyc(2); advanceIn <= 1'b0;
		repeat (150) begin @(posedge mclk); #1 k += (timingPulse === 1'b1); end
		chk(what, 9'(exp), 9'(k));
	endtask
	task automatic issue(input logic host, input logic [2:0] op);
		hostMode <= host; cyc(3); instValid <= 1'b1; opcode <= op; cyc(1); instValid <= 1'b0;
	endtask
	task automatic reportAndStop();
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int k;
		cyc(12); sys_rst <= 1'b0; cyc(3);
		runReq <= 1'b1; cyc(1); runReq <= 1'b0; cyc(2);
		byteStepSw <= SW_ON; cyc(4);
		step("byte burst", 8);
		clockStepSw <= SW_ON; cyc(4);
		chk("clock lamp", 9'h1, clockStepMode);
		step("clock step", 1);
		clockStepSw <= SW_OFF; byteStepSw <= SW_OFF; txSelSw <= SW_ON; cyc(4);
		chk("tx on B", 9'h1, txOnB);
		issue(1'b0, OP_COMPARE);
		#1 chk("compare op", 9'h1, opCompare);
		cmpValid <= 1'b1; cyc(1); cmpValid <= 1'b0; k = 0;
		repeat (20) begin #1 k += (comparatorOut === 1'b1); @(posedge mclk); end
		chk("cmp width", 9'h8, 9'(k));
		issue(1'b0, 3'h7); cyc(3);
		chk("bad op flag", 9'h1, statusWord[ST_INST]);
		issue(1'b1, OP_HOST_REMOTE);
		#1 chk("host op", 9'h1, opHostRemote);
		fork modem.send(8'ha5); join_none
		k = 0;
		while (rxByteValid !== 1'b1 && k < 300) begin @(posedge mclk); #1 k++; end
		chk("rx byte", 9'h0a5, rxByte);
		chk("no code check", 9'h0, statusWord[ST_BCH]);
		hostParityErr <= 1'b1; tapeParityErr <= 1'b1; cyc(1);
		hostParityErr <= 1'b0; tapeParityErr <= 1'b0; cyc(3);
		chk("halted", 9'h0, running);
		chk("tape flag", 9'h1, statusWord[ST_TAPE]);
		hostByteValid <= 1'b1; k = 0;
		repeat (24) begin #1 k += (hostByteReady === 1'b1); @(posedge mclk); end
		chk("fifo fill", 9'(TXF_DEPTH), 9'(k));
		reportAndStop();
	end
	initial begin
		cyc(5000);
		errCount++;
		reportAndStop();
	end
endmodule
bind bus_control_unit bus_control_unit_props props (.*);
